// >>> awsq_pkg.sv
// awsq_pkg: constants and carrier types for the wake/sleep sequencer.
// assumes a 125 MHz system clock; times other than the wake response min and max are converted to cycles here.
package awsq_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_NS = 8;
    // times as printed, in their own units
    localparam int DEGLITCH_NS = 14_000;
    localparam int REG_START_NS = 20_000;
    localparam int WAKE_RESP_MIN_NS = 35_000;
    localparam int WAKE_RESP_TYP_NS = 60_000;
    localparam int WAKE_RESP_MAX_NS = 100_000;
    localparam int SLEEP_WAIT_NS = 4_000;
    localparam int IDLE_TIMEOUT_MS = 1_000;
    localparam int WRITE_BUSY_US = 1_800;
    localparam int SRST_MAX_NS = 30_000;
    localparam int OSC_HZ = 532_000;
    // cycle counts
    localparam int DEGLITCH_CYC = DEGLITCH_NS / CLK_NS;
    localparam int REG_START_CYC = REG_START_NS / CLK_NS;
    localparam int WAKE_RESP_CYC = WAKE_RESP_TYP_NS / CLK_NS;
    localparam int SLEEP_WAIT_CYC = (SLEEP_WAIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int WRITE_BUSY_CYC = WRITE_BUSY_US * (CLK_HZ / 1_000_000);
    localparam int SRST_CYC = (SRST_MAX_NS / CLK_NS) / 2;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    // break length: 1.391 bit-times, in thousandths
    localparam int BREAK_MILLI = 1391;
    localparam int CNT_W = 28;
    // memory layout
    localparam int MEM_DEPTH = 16;
    localparam logic [3:0] ADDR_CFG = 4'h0;
    localparam logic [3:0] ADDR_TRIM = 4'h1;
    localparam logic [3:0] ADDR_SECRET_LO = 4'h2;
    localparam logic [3:0] ADDR_SECRET_HI = 4'hD;
    localparam logic [3:0] ADDR_GP0 = 4'hE;
    // fields of the default configuration byte
    localparam int CFG_LOCK0 = 0;
    localparam int CFG_LOCK1 = 1;
    localparam int CFG_AUTO_SLEEP_ENABLE = 2;
    localparam int CFG_SPD_LO = 3;
    localparam int CFG_DAB_LO = 5;
    localparam logic [7:0] CFG_RESET = 8'h04;

    typedef enum {
        ST_SLEEP, ST_DEGLITCH, ST_REG_UP, ST_LOAD, ST_WAIT_RESP,
        ST_BREAK, ST_IDLE, ST_SLEEP_WAIT, ST_WRITE_BUSY, ST_SRST
    } awsq_state_e;

    typedef struct packed {
        logic [1:0] dev_addr;
        logic [1:0] bus_speed;
        logic auto_sleep;
        logic [1:0] lock;
    } awsq_cfg_s;

    typedef struct packed {
        logic sleep_cmd;
        logic soft_reset;
        logic write_done;
        logic challenge_done;
        logic clr_auto_sleep;
    } awsq_cmd_s;
endpackage : awsq_pkg

// >>> awsq_mem.sv
// awsq_mem: 16-byte nonvolatile store model with registered read.
// assumes the programming interface lives elsewhere; writes are direct, except to the trim byte, which ignores them.
`timescale 1ns/100ps
module awsq_mem
    import awsq_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [7:0] wr_data
);
    logic [7:0] mem [DEPTH];

    // config first, trim, twelve secret bytes, two general bytes
    always_ff @(posedge clk) begin
        if (wr_en && wr_addr != ADDR_TRIM) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : awsq_mem

// >>> awsq_bittimer.sv
// awsq_bittimer: bit-time reference tick from the system clock.
// assumes the divider ratio approximates the internal oscillator.
`timescale 1ns/100ps
module awsq_bittimer
    import awsq_pkg::*;
#(
    parameter int DIV = OSC_DIV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic tick
);
    logic [15:0] cnt_q;

    // bit timing derived from the reference rate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end else if (!run || cnt_q == 16'(DIV - 1)) begin
            cnt_q <= 16'h0000;
            tick <= run;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule : awsq_bittimer

// >>> awsq_seq.sv
// awsq_seq: sleep, wake, power-on and service timing sequencer.
// assumes bus framing logic supplies command pulses on CLK_SYS.
`timescale 1ns/100ps

module awsq_seq
    import awsq_pkg::*;
#(
    parameter int IDLE_CYC = IDLE_TIMEOUT_CYC,
    parameter int BUSY_CYC = WRITE_BUSY_CYC
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // single-wire bus, open drain
    input wire logic SWB_IN,
    output logic SWB_OUT,
    output logic SWB_OE_N,
    // commands from bus framing logic
    input wire awsq_cmd_s CMD,
    // memory write port
    input wire logic MEM_WR_EN,
    input wire logic [3:0] MEM_WR_ADDR,
    input wire logic [7:0] MEM_WR_DATA,
    // status
    output logic REG_ON,
    output logic LOGIC_RST_N,
    output logic AWAKE,
    output logic BUSY,
    output logic HASH_START,
    output logic RESULT_READY,
    output awsq_cfg_s CFG
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic bus_prev;
        awsq_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] idle;
        logic [CNT_W-1:0] since_wake;
        logic [15:0] brk_cnt;
        logic [3:0] bt_cnt;
        logic reg_on;
        logic logic_rst_n;
        logic drive_low;
        logic busy;
        logic hash;
        logic res_wait;
        logic res_ready;
        logic awake;
        awsq_cfg_s cfg;
    } awsq_st_s;

    awsq_st_s s_q, s_d;
    logic [7:0] mem_rd;
    logic tick;

    localparam logic [15:0] BRK_CYC =
        16'((OSC_DIV * BREAK_MILLI) / 1000);

    awsq_mem u_mem (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .rd_addr(ADDR_CFG),
        .rd_data(mem_rd),
        .wr_en(MEM_WR_EN),
        .wr_addr(MEM_WR_ADDR),
        .wr_data(MEM_WR_DATA)
    );

    awsq_bittimer u_bt (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .run(s_q.res_wait),
        .tick(tick)
    );

    function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
        return v + CNT_W'(1);
    endfunction : inc

    logic edge_seen;
    logic bus_low;

    always_comb begin
        s_d = s_q;
        // pad sensed via two flops
        s_d.sync1 = SWB_IN;
        s_d.sync2 = s_q.sync1;
        s_d.bus_prev = s_q.sync2;
        bus_low = !s_q.sync2;
        edge_seen = s_q.sync2 != s_q.bus_prev;
        s_d.since_wake = inc(s_q.since_wake);
        s_d.hash = 1'b0;

        case (s_q.st)
            ST_SLEEP: begin
                // asleep: logic held in reset
                s_d.reg_on = 1'b0;
                s_d.logic_rst_n = 1'b0;
                s_d.drive_low = 1'b0;
                s_d.cnt = '0;
                if (bus_low) begin
                    s_d.st = ST_DEGLITCH;
                    s_d.since_wake = '0;
                end
            end
            ST_DEGLITCH: begin
                s_d.cnt = inc(s_q.cnt);
                if (!bus_low) begin
                    s_d.st = ST_SLEEP; // short glitch ignored
                end else if (s_q.cnt == CNT_W'(DEGLITCH_CYC)) begin
                    s_d.reg_on = 1'b1; // regulator up
                    s_d.st = ST_REG_UP;
                end
            end
            ST_REG_UP: begin
                // no wait for the break to rise
                if (s_q.since_wake >= CNT_W'(REG_START_CYC)) begin
                    s_d.logic_rst_n = 1'b1;
                    s_d.st = ST_LOAD;
                end
            end
            ST_LOAD: begin
                // default config loaded
                s_d.cfg.lock = mem_rd[CFG_LOCK1:CFG_LOCK0];
                s_d.cfg.auto_sleep = mem_rd[CFG_AUTO_SLEEP_ENABLE];
                s_d.cfg.bus_speed = mem_rd[CFG_SPD_LO +: 2];
                s_d.cfg.dev_addr = mem_rd[CFG_DAB_LO +: 2];
                s_d.st = ST_WAIT_RESP;
            end
            ST_WAIT_RESP: begin
                // soft reset skips the wake delay
                if (s_q.since_wake >= CNT_W'(WAKE_RESP_CYC)) begin
                    s_d.st = ST_BREAK;
                    s_d.drive_low = 1'b1; // ready break
                    s_d.brk_cnt = '0;
                end
            end
            ST_BREAK: begin
                s_d.brk_cnt = s_q.brk_cnt + 16'h0001;
                if (s_q.brk_cnt == BRK_CYC - 16'h0001) begin
                    s_d.drive_low = 1'b0; // 1.391 bit-times
                    s_d.st = ST_IDLE;
                    s_d.idle = '0;
                end
            end
            ST_IDLE: begin
                // awake: low pulses are data, no wake path
                s_d.idle = edge_seen ? '0 : inc(s_q.idle);
                if (CMD.clr_auto_sleep) begin
                    s_d.cfg.auto_sleep = 1'b0;
                end
                if (CMD.soft_reset) begin
                    s_d.st = ST_SRST;
                    s_d.cnt = '0;
                end else if (CMD.sleep_cmd) begin
                    s_d.st = ST_SLEEP_WAIT;
                    s_d.cnt = '0;
                end else if (CMD.write_done) begin
                    s_d.st = ST_WRITE_BUSY;
                    s_d.busy = 1'b1;
                    s_d.cnt = '0;
                end else if (s_q.cfg.auto_sleep &&
                             s_q.idle >= CNT_W'(IDLE_CYC - 1)) begin
                    s_d.st = ST_SLEEP; // idle timeout
                end
                if (CMD.challenge_done) begin
                    s_d.hash = 1'b1;
                    s_d.res_wait = 1'b1;
                    s_d.res_ready = 1'b0;
                end
            end
            ST_SLEEP_WAIT: begin
                s_d.cnt = inc(s_q.cnt);
                if (s_q.cnt >= CNT_W'(SLEEP_WAIT_CYC)) begin
                    s_d.st = ST_SLEEP;
                end
            end
            ST_WRITE_BUSY: begin
                s_d.cnt = inc(s_q.cnt);
                if (s_q.cnt >= CNT_W'(BUSY_CYC - 1)) begin
                    s_d.busy = 1'b0;
                    s_d.st = ST_IDLE;
                    s_d.idle = '0;
                end
            end
            ST_SRST: begin
                // reload then break well inside the limit
                s_d.cnt = inc(s_q.cnt);
                s_d.res_ready = 1'b0;
                if (s_q.cnt >= CNT_W'(SRST_CYC)) begin
                    s_d.since_wake = CNT_W'(WAKE_RESP_CYC);
                    s_d.st = ST_LOAD;
                end
            end
            default: s_d.st = ST_SLEEP;
        endcase

        if (s_q.res_wait && tick) begin
            s_d.res_wait = 1'b0;
            s_d.res_ready = 1'b1; // one bit-time later
        end
        if (s_d.st == ST_SLEEP) begin
            // regulator and logic reset fall with the state, not a cycle
            // later, so no asleep cycle ever shows live logic
            s_d.reg_on = 1'b0;
            s_d.logic_rst_n = 1'b0;
            s_d.drive_low = 1'b0;
            s_d.res_wait = 1'b0;
            s_d.res_ready = 1'b0;
            s_d.busy = 1'b0;
        end
        // registered copy keeps the status output glitch free
        s_d.awake = s_d.st != ST_SLEEP;
        // saturate the wake-time counter
        if (s_q.since_wake == '1) begin
            s_d.since_wake = s_q.since_wake;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            // released bus idles high: synchronisers start high so that
            // reset never looks like a falling wake edge
            s_q <= '{
                sync1: 1'b1,
                sync2: 1'b1,
                bus_prev: 1'b1,
                st: ST_SLEEP,
                // auto-sleep on from power-up
                cfg: '{auto_sleep: 1'b1, default: '0},
                default: '0
            };
        end else begin
            s_q <= s_d;
        end
    end

    // only ever pull low, else release
    assign SWB_OUT = 1'b0;
    assign SWB_OE_N = !s_q.drive_low;
    assign REG_ON = s_q.reg_on;
    assign LOGIC_RST_N = s_q.logic_rst_n;
    assign AWAKE = s_q.awake;
    assign BUSY = s_q.busy;
    assign HASH_START = s_q.hash;
    assign RESULT_READY = s_q.res_ready;
    assign CFG = s_q.cfg;
endmodule : awsq_seq

// >>> awsq_seq_monitor.sv
// awsq_seq_monitor: port timing checks for the sequencer.
// assumes one clock; counts come in as the dut's parameters.
`timescale 1ns/100ps
module awsq_seq_monitor
    import awsq_pkg::*;
#(
    parameter int IDLE_CYC = IDLE_TIMEOUT_CYC,
    parameter int BUSY_CYC = WRITE_BUSY_CYC
) (
    // clock, reset, bus
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic SWB_IN,
    input wire logic SWB_OUT,
    input wire logic SWB_OE_N,
    // commands and status
    input wire awsq_cmd_s CMD,
    input wire logic REG_ON,
    input wire logic LOGIC_RST_N,
    input wire logic AWAKE,
    input wire logic BUSY,
    input wire logic HASH_START,
    input wire logic RESULT_READY
);
    localparam int CAP = 1_000_000;
    localparam int FALL = 0, SRST = 1, SLP = 2, WR = 3;
    localparam int CHAL = 4, LOW = 5, OE = 6, IDL = 7;
    int n [8];
    logic swb_q;
    logic [7:0] clr;
    // saturate so an old event never looks recent
    function automatic int up(int v);
        return (v < CAP) ? v + 1 : v;
    endfunction : up
    assign clr = {SWB_IN != swb_q, SWB_OE_N, SWB_IN, CMD.challenge_done,
        CMD.write_done, CMD.sleep_cmd, CMD.soft_reset,
        swb_q && !SWB_IN && !AWAKE};
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            swb_q <= 1'b1;
            foreach (n[i]) n[i] <= CAP;
        end else begin
            swb_q <= SWB_IN;
            foreach (n[i]) n[i] <= clr[i] ? 0 : up(n[i]);
        end
    end
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESET_N);
    property p_asleep;
        !AWAKE |-> !REG_ON && !LOGIC_RST_N && SWB_OE_N;
    endproperty
    a_asleep: assert property (p_asleep)
        else $error("logic active while asleep");
    property p_deglitch;
        $rose(REG_ON) |-> n[LOW] inside {[875:2510]};
    endproperty
    a_deglitch: assert property (p_deglitch)
        else $error("wake pulse width out of window");
    property p_por;
        $rose(LOGIC_RST_N) |-> n[FALL] inside {[2450:2560]} || n[SRST] < 3750;
    endproperty
    a_por: assert property (p_por)
        else $error("logic reset release mistimed");
    property p_resp;
        $fell(SWB_OE_N) |-> LOGIC_RST_N
            && (n[FALL] inside {[4375:12500]} || n[SRST] <= 3750);
    endproperty
    a_resp: assert property (p_resp)
        else $error("ready break mistimed");
    property p_brk;
        $rose(SWB_OE_N) |-> n[OE] inside {[324:328]};
    endproperty
    a_brk: assert property (p_brk)
        else $error("ready break length wrong");
    property p_drive;
        SWB_OUT == 1'b0 && (SWB_OE_N || !SWB_IN);
    endproperty
    a_drive: assert property (p_drive)
        else $error("bus driven high");
    property p_sleep;
        $fell(REG_ON) |-> n[SLP] inside {[500:1000]}
            || n[IDL] inside {[IDLE_CYC * 9 / 10:IDLE_CYC * 11 / 10]};
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("regulator off without cause");
    property p_busy;
        $fell(BUSY) |-> n[WR] inside {[BUSY_CYC * 17 / 18:BUSY_CYC * 19 / 18]};
    endproperty
    a_busy: assert property (p_busy)
        else $error("write busy length wrong");
    property p_hash;
        HASH_START |-> n[CHAL] <= 3;
    endproperty
    a_hash: assert property (p_hash)
        else $error("hash start not after challenge");
    property p_result;
        $rose(RESULT_READY) |-> n[CHAL] inside {[200:275]};
    endproperty
    a_result: assert property (p_result)
        else $error("result ready mistimed");
    c_wake: cover property ($rose(LOGIC_RST_N));
    c_idle: cover property ($fell(REG_ON) && n[IDL] > IDLE_CYC / 2);
    c_result: cover property ($rose(RESULT_READY));
endmodule : awsq_seq_monitor

// >>> awsq_host.sv
// awsq_host: host side of the single-wire bus with its pull-up.
// assumes the bench picks break widths, narrow ones on purpose.
`timescale 1ns/100ps
module awsq_host (
    input wire logic clk,
    input wire logic dev_oe_n,
    output logic bus_lvl
);
    logic host_low = 1'b0;
    // released wire floats high through the pull-up
    assign bus_lvl = !(host_low || !dev_oe_n);
    // wake break width chosen by caller
    task automatic send_break(input int cycles);
        @(posedge clk);
        host_low <= 1'b1;
        repeat (cycles) @(posedge clk);
        host_low <= 1'b0;
    endtask : send_break
endmodule : awsq_host

// >>> tb.sv
// tb: self-checking bench for the wake/sleep sequencer.
// assumes shortened idle and busy counts; host model owns the wire.
`timescale 1ns/100ps
module tb;
    import awsq_pkg::*;
    localparam int IDLE_CYC = 10000;
    localparam int BUSY_CYC = 2000;
    localparam logic [4:0] SLP = 5'h10, SRST = 5'h08, WR = 5'h04;
    localparam logic [4:0] CHAL = 5'h02, CLR = 5'h01;
    // addr 2, speed 1, auto-sleep on, lock 2
    localparam logic [7:0] CFG_BYTE = 8'h4E;
    typedef struct {
        int width;
        logic wake;
    } awsq_row_s;
    awsq_row_s rows [4] = '{'{100, 1'b0}, '{1500, 1'b0}, '{3000, 1'b1},
        '{9000, 1'b1}};
    logic CLK_SYS = 1'b0;
    logic RESET_N = 1'b0;
    logic MEM_WR_EN = 1'b0;
    logic [7:0] MEM_WR_DATA = 8'h00;
    awsq_cmd_s CMD = '0;
    awsq_cfg_s CFG;
    logic SWB_IN, SWB_OUT, SWB_OE_N, REG_ON, LOGIC_RST_N, AWAKE, BUSY;
    logic HASH_START, RESULT_READY;
    logic oe_q = 1'b1;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int t_brk = -1;
    int t0 = 0;
    int n_hash = 0;
    awsq_seq #(.IDLE_CYC(IDLE_CYC), .BUSY_CYC(BUSY_CYC)) dut (
        .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .SWB_IN(SWB_IN),
        .SWB_OUT(SWB_OUT), .SWB_OE_N(SWB_OE_N), .CMD(CMD),
        .MEM_WR_EN(MEM_WR_EN), .MEM_WR_ADDR(4'h0), .MEM_WR_DATA(MEM_WR_DATA),
        .REG_ON(REG_ON), .LOGIC_RST_N(LOGIC_RST_N), .AWAKE(AWAKE),
        .BUSY(BUSY), .HASH_START(HASH_START), .RESULT_READY(RESULT_READY),
        .CFG(CFG));
    awsq_host host (.clk(CLK_SYS), .dev_oe_n(SWB_OE_N), .bus_lvl(SWB_IN));
    initial forever #4 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        oe_q <= SWB_OE_N;
        if (oe_q === 1'b1 && SWB_OE_N === 1'b0) t_brk <= cyc;
        if (HASH_START === 1'b1) n_hash <= n_hash + 1;
    end
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic chk_rng(input string what, input int lo, hi, got);
        n_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("unexpected %s: expected %0d..%0d seen %0d", what, lo,
                hi, got);
        end
    endtask : chk_rng
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge CLK_SYS);
    endtask : wait_cyc
    task automatic pulse(input logic [4:0] c);
        @(posedge CLK_SYS);
        CMD <= c;
        @(posedge CLK_SYS);
        CMD <= '0;
    endtask : pulse
    task automatic end_of_test;
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    initial begin
        wait_cyc(95000);
        errors++;
        end_of_test();
    end
    initial begin
        wait_cyc(5);
        RESET_N <= 1'b1;
        wait_cyc(2);
        chk("AWAKE", 1'b0, AWAKE);
        chk("LOGIC_RST_N", 1'b0, LOGIC_RST_N);
        chk("SWB_OUT", 1'b0, SWB_OUT);
        chk("CFG.auto_sleep", 1'b1, CFG.auto_sleep);
        MEM_WR_EN <= 1'b1;
        MEM_WR_DATA <= CFG_BYTE;
        @(posedge CLK_SYS);
        MEM_WR_EN <= 1'b0;
        foreach (rows[i]) begin
            t0 = cyc;
            t_brk = -1;
            host.send_break(rows[i].width);
            wait_cyc(rows[i].wake ? 13000 - rows[i].width : 3000);
            chk("AWAKE", rows[i].wake, AWAKE);
            if (rows[i].wake) begin
                chk_rng("wake break", 4375, 12502, t_brk - t0);
                chk("LOGIC_RST_N", 1'b1, LOGIC_RST_N);
                chk("CFG", CFG_BYTE[6:0], CFG);
                pulse(SLP);
                wait_cyc(450);
                chk("REG_ON", 1'b1, REG_ON);
                wait_cyc(650);
                chk("AWAKE", 1'b0, AWAKE);
            end else chk_rng("wake break", -1, -1, t_brk);
        end
        host.send_break(3000);
        wait_cyc(10000);
        // awake: a narrow low is a data bit, no new ready break
        t_brk = -1;
        host.send_break(1500);
        wait_cyc(3000);
        chk("AWAKE", 1'b1, AWAKE);
        chk_rng("break", -1, -1, t_brk);
        t0 = cyc;
        pulse(WR);
        wait_cyc(100);
        chk("BUSY", 1'b1, BUSY);
        pulse(SLP);
        for (int i = 0; i < 3000 && BUSY !== 1'b0; i++) @(posedge CLK_SYS);
        chk_rng("busy time", BUSY_CYC, BUSY_CYC * 19 / 18 + 3, cyc - t0);
        chk("REG_ON", 1'b1, REG_ON);
        t0 = cyc;
        pulse(CHAL);
        for (int i = 0; i < 400 && RESULT_READY !== 1'b1; i++)
            @(posedge CLK_SYS);
        chk_rng("result time", 200, 278, cyc - t0);
        chk("HASH_START pulses", 1, n_hash);
        pulse(CLR);
        wait_cyc(12000);
        chk("AWAKE", 1'b1, AWAKE);
        t0 = cyc;
        t_brk = -1;
        pulse(SRST);
        wait_cyc(4000);
        chk_rng("reset break", 1, 3752, t_brk - t0);
        chk("CFG.auto_sleep", 1'b1, CFG.auto_sleep);
        wait_cyc(4500);
        chk("AWAKE", 1'b1, AWAKE);
        wait_cyc(6000);
        chk("AWAKE", 1'b0, AWAKE);
        end_of_test();
    end
endmodule : tb
bind awsq_seq awsq_seq_monitor #(.IDLE_CYC(IDLE_CYC), .BUSY_CYC(BUSY_CYC))
    u_mon (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .SWB_IN(SWB_IN),
    .SWB_OUT(SWB_OUT), .SWB_OE_N(SWB_OE_N), .CMD(CMD), .REG_ON(REG_ON),
    .LOGIC_RST_N(LOGIC_RST_N), .AWAKE(AWAKE), .BUSY(BUSY),
    .HASH_START(HASH_START), .RESULT_READY(RESULT_READY));
